// [isolated_logic_output_channel.sv]
// Isolated logic output channel: on/off or time-proportioning drive
`timescale 1ns/1ps
// ============================================================
// Functional notes
// - Only plain switching or time proportioning
// - Non-inverted: demand off 0, on 1
// - Inverted: inactive drives 1, active 0
// - Standby Off forces low, ignores inversion
// - Standby On forces high, ignores inversion
// - Standby continue keeps normal demand drive
// - Readable measured output state bit
// - Demand from upstream, writable when unwired
// - Timing and scaling only in time proportioning
// - Period Off selects minimum duration algorithm
// - Any period value selects fixed cycle
// - Minimum on/off duration, Auto 110 ms
// - Minimum duration only when period Off
module isolated_logic_output_channel
  import logic_out_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_standby,
  input wire logic i_demand_wired,
  input wire logic i_demand_bit,
  input wire logic [15:0] i_demand_level,
  output logic o_drive
);

  // ==========================================================
  // Registers and internal state
  ctrl_t ctrl; // Function, inversion, standby action
  logic demand_bit_reg; // Software demand bit
  logic [15:0] demand_level_reg; // Software analogue demand
  logic [15:0] period; // Cycle period in ticks, 0 = Off
  logic [15:0] min_time; // Minimum duration, 0 = Auto
  limits_t disp; // Demand scale limits
  limits_t range_lim; // Electrical scale limits
  logic apb_done; // Access phase completes
  logic [31:0] next_rdata;
  logic next_err;
  logic demand_bit; // Selected on/off demand
  logic [15:0] demand_level; // Selected analogue demand
  logic [15:0] scaled; // Electrical demand, hundredths
  logic [31:0] tick_cnt; // Time base divider
  logic tick; // One pulse every 10 ms
  logic [15:0] cyc_cnt; // Position within cycle
  logic cyc_mode; // Fixed cycle algorithm running
  logic min_mode; // Minimum duration algorithm running
  logic cyc_on;
  logic [15:0] min_ticks; // Effective minimum duration
  logic [15:0] dwell; // Ticks since last change
  logic dwell_ok;
  logic signed [31:0] acc; // On-time error integral
  logic want, mt_out, mt_toggle; // Minimum duration decision
  logic logical; // Output state before inversion
  logic next_drive;

  // ==========================================================
  // APB slave
  assign apb_done = i_psel & i_penable & o_pready;
  // Ready rises for the access phase after every setup cycle
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_pready <= 1'b0;
    end else begin
      o_pready <= i_psel & ~i_penable;
    end
  end
  // Read data and error are captured in the setup cycle
  always_comb begin
    next_rdata = 32'h0;
    next_err = 1'b0;
    case (i_paddr)
      OFS_CTRL: next_rdata[CTRL_W-1:0] = ctrl;
      OFS_DEMAND: begin
        next_rdata[0] = demand_bit_reg;
        next_rdata[DEM_LVL_LSB +: 16] = demand_level_reg;
      end
      OFS_PERIOD: next_rdata[HALF_MSB:0] = period;
      OFS_MINTIME: next_rdata[HALF_MSB:0] = min_time;
      OFS_DISP: next_rdata = disp;
      OFS_RANGE: next_rdata = range_lim;
      OFS_STATUS: begin
        next_rdata[0] = o_drive;
        next_rdata[1] = logical;
        next_rdata[HALF_LSB +: 16] = scaled;
      end
      // Unmapped addresses answer with an error
      default: next_err = 1'b1;
    endcase
  end
  // Read path registers
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_prdata <= 32'h0;
      o_pslverr <= 1'b0;
    end else if (i_psel & ~i_penable) begin
      o_prdata <= next_rdata;
      o_pslverr <= next_err;
    end
  end
  // Register writes; out-of-range times are clamped
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      ctrl <= ctrl_t'(4'h0);
      demand_bit_reg <= 1'b0;
      demand_level_reg <= 16'h0;
      period <= 16'h0;
      min_time <= MIN_DEF_T;
      disp <= {DISP_HI_DEF, DISP_LO_DEF};
      range_lim <= {RANGE_HI_DEF, RANGE_LO_DEF};
    end else if (apb_done && i_pwrite) begin
      case (i_paddr)
        // one bit picks one of two functions
        OFS_CTRL: ctrl <= ctrl_t'(i_pwdata[CTRL_W-1:0]);
        OFS_DEMAND: begin
          demand_bit_reg <= i_pwdata[0];
          demand_level_reg <= i_pwdata[DEM_LVL_LSB +: 16];
        end
        // zero is Off, others held in range
        OFS_PERIOD: begin
          if (i_pwdata[HALF_MSB:0] == 16'h0) begin
            period <= 16'h0;
          end else if (i_pwdata[HALF_MSB:0] < PERIOD_MIN_T) begin
            period <= PERIOD_MIN_T;
          end else if (i_pwdata[HALF_MSB:0] > PERIOD_MAX_T) begin
            period <= PERIOD_MAX_T;
          end else begin
            period <= i_pwdata[HALF_MSB:0];
          end
        end
        OFS_MINTIME: begin
          min_time <= (i_pwdata[HALF_MSB:0] > MIN_MAX_T) ?
                      MIN_MAX_T : i_pwdata[HALF_MSB:0];
        end
        OFS_DISP: disp <= i_pwdata;
        OFS_RANGE: range_lim <= i_pwdata;
        // Status is read-only; unmapped writes are dropped
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Demand source
  // upstream when wired, register otherwise
  always_comb begin
    demand_bit = i_demand_wired ? i_demand_bit : demand_bit_reg;
    demand_level = i_demand_wired ? i_demand_level
                                  : demand_level_reg;
  end

  // ==========================================================
  // Scaling; the divider is deep but it settles in one cycle
  // linear map onto electrical limits
  always_comb begin
    logic signed [31:0] lvl, dlo, dhi, rlo, rhi, num, den, s;
    lvl = signed'(32'(demand_level));
    dlo = signed'(32'(disp.lo));
    dhi = signed'(32'(disp.hi));
    rlo = signed'(32'(range_lim.lo));
    rhi = signed'(32'(range_lim.hi));
    lvl = (lvl > dhi) ? dhi : lvl;
    lvl = (lvl < dlo) ? dlo : lvl;
    den = dhi - dlo;
    num = (lvl - dlo) * (rhi - rlo);
    // Collapsed display span pins the output at range low
    s = (den > 0) ? rlo + num / den : rlo;
    s = (s < 0) ? 32'sh0 : s;
    s = (s > signed'(32'(FULL_SCALE))) ? signed'(32'(FULL_SCALE)) : s;
    scaled = s[15:0];
  end

  // ==========================================================
  // Time base divider
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      tick_cnt <= 32'h0;
      tick <= 1'b0;
    end else if (tick_cnt == 32'(TICK_CYCLES - 1)) begin
      tick_cnt <= 32'h0;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 32'h1;
      tick <= 1'b0;
    end
  end

  assign cyc_mode = (ctrl.func == FN_TIMEPROP) && (period != 16'h0);
  assign min_mode = (ctrl.func == FN_TIMEPROP) && (period == 16'h0);

  // ==========================================================
  // Fixed cycle counter; wraps at once if period shrinks
  // count through the set period
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || !cyc_mode || cyc_cnt >= period) begin
      cyc_cnt <= 16'h0;
    end else if (tick) begin
      if (cyc_cnt == period - 16'h1) begin
        cyc_cnt <= 16'h0;
      end else begin
        cyc_cnt <= cyc_cnt + 16'h1;
      end
    end
  end
  // on while position is below duty share
  assign cyc_on = (32'(cyc_cnt) * 32'(FULL_SCALE)) <
                  (32'(scaled) * 32'(period));

  // ==========================================================
  // Minimum duration algorithm: integrate error, hold changes
  // Auto means 110 ms
  assign min_ticks = (min_time == 16'h0) ? MIN_AUTO_T : min_time;
  assign dwell_ok = dwell >= min_ticks;
  assign want = acc > 0;
  assign mt_toggle = min_mode && tick && dwell_ok && (want != mt_out);
  // Error integral; cleared whenever the algorithm is idle
  // only active with period Off
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || !min_mode) begin
      acc <= 32'sh0;
    end else if (tick) begin
      acc <= acc + signed'(32'(scaled))
             - (mt_out ? signed'(32'(FULL_SCALE)) : 32'sh0);
    end
  end
  // Output of the minimum duration algorithm
  // change only after the minimum duration
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || !min_mode) begin
      mt_out <= 1'b0;
    end else if (mt_toggle) begin
      mt_out <= want;
    end
  end
  // Dwell counter saturates so long holds never wrap
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || !min_mode || mt_toggle) begin
      dwell <= 16'h0;
    end else if (tick && dwell != 16'hffff) begin
      dwell <= dwell + 16'h1;
    end
  end

  // ==========================================================
  // Output selection and polarity
  always_comb begin
    case (ctrl.func)
      FN_TIMEPROP: logical = min_mode ? mt_out : cyc_on;
      default: logical = demand_bit;
    endcase
    case ({i_standby, ctrl.standby_action})
      {1'b1, SBY_OFF}: next_drive = 1'b0;
      {1'b1, SBY_ON}: next_drive = 1'b1;
      default: next_drive = logical ^ ctrl.invert;
    endcase
  end
  // Output flop feeding the isolated driver
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_drive <= 1'b0;
    end else begin
      o_drive <= next_drive;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  a_standby_low: assert property (
    (i_standby && ctrl.standby_action == SBY_OFF) |=> !o_drive)
    else $error("standby off did not force low");
  a_standby_high: assert property (
    (i_standby && ctrl.standby_action == SBY_ON) |=> o_drive)
    else $error("standby on did not force high");
  a_plain_normal: assert property (
    (ctrl.func == FN_PLAIN && !i_standby && !ctrl.invert)
    |=> o_drive == $past(demand_bit))
    else $error("plain output does not follow demand");
  a_plain_invert: assert property (
    (ctrl.func == FN_PLAIN && !i_standby && ctrl.invert)
    |=> o_drive != $past(demand_bit))
    else $error("inverted output not opposite to demand");
  a_standby_cont: assert property (
    (i_standby && ctrl.standby_action == SBY_CONT &&
     ctrl.func == FN_PLAIN && !ctrl.invert)
    |=> o_drive == $past(demand_bit))
    else $error("standby continue lost the demand");
  a_meas_read: assert property (
    (i_psel && !i_penable && i_paddr == OFS_STATUS)
    |=> o_prdata[0] == $past(o_drive))
    else $error("status does not show output state");
  a_cycle_bound: assert property (
    cyc_mode |-> ##[0:2] cyc_cnt < period)
    else $error("cycle position beyond period");
  a_cycle_duty: assert property (
    (cyc_mode && !i_standby && !ctrl.invert && scaled == 16'h0)
    |=> !o_drive)
    else $error("zero demand drove output in cycle mode");
  a_min_dwell: assert property (
    ($past(min_mode) && mt_out != $past(mt_out))
    |-> $past(dwell_ok))
    else $error("output changed before minimum duration");
  a_min_idle: assert property (
    !min_mode |=> (acc == 32'sh0 && !mt_out))
    else $error("minimum duration ran with period set");
  a_scale_top: assert property (
    (disp == {FULL_SCALE, 16'h0} && range_lim == disp &&
     demand_level >= FULL_SCALE) |-> scaled == FULL_SCALE)
    else $error("full demand did not scale to full");
  c_cycle_on: cover property (cyc_mode && cyc_on ##1 o_drive);
  c_min_toggle: cover property (mt_toggle && want);
  c_standby_hi: cover property (i_standby ##1 o_drive);
  c_bus_error: cover property (apb_done && o_pslverr);

endmodule : isolated_logic_output_channel

// [isolated_logic_output_channel_bench.sv]
// Self-checking bench for the isolated logic output channel
`timescale 1ns/1ps
module isolated_logic_output_channel_bench;
  import logic_out_pkg::*;
  localparam int TK = 4; // Short tick keeps the run brief
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] pa = 8'h00;
  logic [31:0] pwd = 32'h0;
  logic [31:0] prd;
  logic rdy;
  logic err;
  logic sby = 1'b0;
  logic wired = 1'b0;
  logic dbit = 1'b0;
  logic [15:0] dlvl = 16'h0000;
  logic drv;
  logic meas = 1'b0;
  logic [15:0] on_n;
  logic [15:0] edg_n;
  logic [15:0] dwell;
  logic [31:0] rv; // Data of the last read
  logic re; // Error flag of the last transfer
  int n_errors = 0;
  int samples_checked = 0;

  // ==========================================================
  // Clock and instances
  always #5 i_sys_clk = ~i_sys_clk;

  isolated_logic_output_channel #(
    .TICK_CYCLES(TK)
  ) isolated_logic_output_channel_inst (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_psel(psel),
    .i_penable(pen),
    .i_pwrite(pwr),
    .i_paddr(pa),
    .i_pwdata(pwd),
    .o_prdata(prd),
    .o_pready(rdy),
    .o_pslverr(err),
    .i_standby(sby),
    .i_demand_wired(wired),
    .i_demand_bit(dbit),
    .i_demand_level(dlvl),
    .o_drive(drv)
  );

  switching_load_model switching_load_model_inst (
    .i_sys_clk(i_sys_clk),
    .i_load_drive(drv),
    .i_measure(meas),
    .o_on_cycles(on_n),
    .o_edges(edg_n),
    .o_min_dwell(dwell)
  );

  // ==========================================================
  // Shared tasks
  task automatic complete_run;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string nm, input logic [31:0] x,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== x) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, x, g);
    end
  endtask : chk

  // One APB transfer; the wait for ready is bounded
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge i_sys_clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge i_sys_clk);
    pen <= 1'b1;
    k = 0;
    do begin
      @(posedge i_sys_clk);
      k++;
    end while (rdy !== 1'b1 && k < 16);
    rv = prd;
    re = err;
    psel <= 1'b0;
    pen <= 1'b0;
    if (rdy !== 1'b1) begin
      n_errors++;
      $display("[FAIL] apb ready expected 1 seen %b", rdy);
      complete_run;
    end
  endtask : apb

  task automatic rdchk(input string nm, input logic [7:0] a,
                       input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(nm, x, rv);
  endtask : rdchk

  // Drive is registered, so a few edges are let pass first
  task automatic drvchk(input string nm, input logic x);
    repeat (4) @(posedge i_sys_clk);
    #1;
    chk(nm, {31'h0, x}, {31'h0, drv});
  endtask : drvchk

  // Warm up, then count over n cycles in the load model
  task automatic measure(input int n);
    repeat (120) @(posedge i_sys_clk);
    meas <= 1'b1;
    repeat (n) @(posedge i_sys_clk);
    meas <= 1'b0;
    #1;
  endtask : measure

  // ==========================================================
  // Scenarios
  task automatic t_defaults;
    rdchk("ctrl", OFS_CTRL, 32'h0);
    rdchk("period", OFS_PERIOD, 32'h0);
    rdchk("mintime", OFS_MINTIME, {16'h0, MIN_DEF_T});
    rdchk("disp", OFS_DISP, {DISP_HI_DEF, DISP_LO_DEF});
    rdchk("range", OFS_RANGE, {RANGE_HI_DEF, RANGE_LO_DEF});
    // Out-of-range times are clamped to the nearest legal value
    apb(1'b1, OFS_PERIOD, 32'h5);
    rdchk("period low", OFS_PERIOD, {16'h0, PERIOD_MIN_T});
    apb(1'b1, OFS_PERIOD, 32'hffff);
    rdchk("period high", OFS_PERIOD, {16'h0, PERIOD_MAX_T});
    apb(1'b1, OFS_MINTIME, 32'hffff);
    rdchk("mintime high", OFS_MINTIME, {16'h0, MIN_MAX_T});
    apb(1'b1, 8'h40, 32'h1);
    chk("unmapped error", 32'h1, {31'h0, re});
  endtask : t_defaults

  task automatic t_polarity;
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, OFS_CTRL, {30'h0, i[1], 1'b0});
      apb(1'b1, OFS_DEMAND, {31'h0, i[0]});
      drvchk("drive", i[0] ^ i[1]);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk("state", {31'h0, i[0] ^ i[1]}, {31'h0, rv[0]});
    end
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b1, OFS_DEMAND, 32'h0);
    @(posedge i_sys_clk);
    wired <= 1'b1;
    dbit <= 1'b1;
    drvchk("wired demand", 1'b1);
    @(posedge i_sys_clk);
    wired <= 1'b0;
    drvchk("register demand", 1'b0);
  endtask : t_polarity

  // Inverted, both demands per action, so each forced level differs once from the normal level
  task automatic t_standby;
    logic x;
    @(posedge i_sys_clk);
    sby <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, OFS_CTRL, {28'h0, 2'(i / 2), 2'b10});
      apb(1'b1, OFS_DEMAND, {31'h0, i[0]});
      x = (i / 2 == 0) ? 1'b0 : ((i / 2 == 1) ? 1'b1 : ~i[0]);
      drvchk("standby drive", x);
    end
    @(posedge i_sys_clk);
    sby <= 1'b0;
  endtask : t_standby

  // Period of 10 ticks is 40 cycles; the window spans ten
  task automatic t_cycle;
    logic [15:0] lv [4] = '{16'h1388, 16'h0bb8, 16'h2710, 16'h0000};
    int ex [4] = '{200, 120, 400, 0};
    apb(1'b1, OFS_CTRL, 32'h1);
    apb(1'b1, OFS_PERIOD, 32'ha);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, OFS_DEMAND, {lv[i], 16'h0});
      measure(400);
      chk("on cycles", 32'(ex[i]), {16'h0, on_n});
    end
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b1, OFS_DEMAND, 32'h13880000);
    measure(400);
    chk("plain on cycles", 32'h0, {16'h0, on_n});
  endtask : t_cycle

  task automatic t_scaling;
    apb(1'b1, OFS_CTRL, 32'h1);
    apb(1'b1, OFS_RANGE, 32'h13880000);
    apb(1'b1, OFS_DEMAND, 32'h27100000);
    measure(400);
    chk("range on cycles", 32'd200, {16'h0, on_n});
    apb(1'b1, OFS_RANGE, 32'h27100000);
    apb(1'b1, OFS_DISP, 32'h27101388);
    apb(1'b1, OFS_DEMAND, 32'h1d4c0000);
    measure(400);
    chk("disp on cycles", 32'd200, {16'h0, on_n});
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("disp scaled", 32'h1388, {16'h0, rv[31:16]});
    apb(1'b1, OFS_DISP, 32'h27100000);
    // Upstream analogue demand replaces the register level
    @(posedge i_sys_clk);
    wired <= 1'b1;
    dlvl <= 16'h0bb8;
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("wired level", 32'h0bb8, {16'h0, rv[31:16]});
    @(posedge i_sys_clk);
    wired <= 1'b0;
  endtask : t_scaling

  // Period Off: no run may be shorter than the minimum dwell
  task automatic t_min;
    int tk [2] = '{5, 11};
    logic [31:0] mt [2] = '{32'h5, 32'h0};
    apb(1'b1, OFS_PERIOD, 32'h0);
    apb(1'b1, OFS_DEMAND, 32'h13880000);
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, OFS_MINTIME, mt[i]);
      measure(1600);
      chk("edges", 32'h1, {31'h0, edg_n > 16'h1});
      chk("dwell", 32'h1, {31'h0, dwell >= 16'(tk[i] * TK)});
    end
  endtask : t_min

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    repeat (8) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    @(posedge i_sys_clk);
    t_defaults;
    t_polarity;
    t_standby;
    t_cycle;
    t_scaling;
    t_min;
    complete_run;
  end

  initial begin
    #500_000;
    n_errors++;
    $display("[FAIL] watchdog expected finish seen hang");
    complete_run;
  end
endmodule : isolated_logic_output_channel_bench

// [logic_out_pkg.sv]
// Constants, register map and types for the isolated logic output channel
package logic_out_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DEMAND = 8'h04;
  localparam logic [7:0] OFS_PERIOD = 8'h08;
  localparam logic [7:0] OFS_MINTIME = 8'h0c;
  localparam logic [7:0] OFS_DISP = 8'h10;
  localparam logic [7:0] OFS_RANGE = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;

  // ==========================================================
  // Field positions
  localparam int CTRL_W = 4;
  localparam int DEM_LVL_LSB = 16;
  localparam int HALF_MSB = 15;
  localparam int HALF_LSB = 16;

  // ==========================================================
  // Timing: one tick of the time base is 10 ms
  localparam int CLK_HZ = 100_000_000;
  localparam int TICK_MS = 10;
  localparam int TICK_CYCLES_DEF = CLK_HZ / 1000 * TICK_MS;
  localparam int PERIOD_MIN_MS = 100;
  localparam int PERIOD_MAX_MS = 20_000;
  localparam int MIN_MAX_MS = 150_000;
  localparam int MIN_DEF_MS = 5_000;
  localparam int MIN_AUTO_MS = 110;
  localparam logic [15:0] PERIOD_MIN_T = 16'(PERIOD_MIN_MS / TICK_MS);
  localparam logic [15:0] PERIOD_MAX_T = 16'(PERIOD_MAX_MS / TICK_MS);
  localparam logic [15:0] MIN_MAX_T = 16'(MIN_MAX_MS / TICK_MS);
  localparam logic [15:0] MIN_DEF_T = 16'(MIN_DEF_MS / TICK_MS);
  localparam logic [15:0] MIN_AUTO_T = 16'(MIN_AUTO_MS / TICK_MS);

  // ==========================================================
  // Scaling, in hundredths: 100.00 is full scale
  localparam logic [15:0] FULL_SCALE = 16'h2710;
  localparam logic [15:0] DISP_HI_DEF = 16'h2710;
  localparam logic [15:0] DISP_LO_DEF = 16'h0000;
  localparam logic [15:0] RANGE_HI_DEF = 16'h2710;
  localparam logic [15:0] RANGE_LO_DEF = 16'h0000;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    SBY_OFF = 2'h0,
    SBY_ON = 2'h1,
    SBY_CONT = 2'h2
  } standby_action_t;

  typedef enum logic {
    FN_PLAIN = 1'b0,
    FN_TIMEPROP = 1'b1
  } out_function_t;

  // Control word: bit0 function, bit1 invert, bits3:2 standby
  typedef struct packed {
    standby_action_t standby_action;
    logic invert;
    out_function_t func;
  } ctrl_t;

  // Limit pair: hi in bits 31:16, lo in bits 15:0
  typedef struct packed {
    logic [15:0] hi;
    logic [15:0] lo;
  } limits_t;

endpackage : logic_out_pkg

// [switching_load_model.sv]
// Behavioural solid-state relay load that times the logic drive it sees
`timescale 1ns/1ps
module switching_load_model (
  input wire logic i_sys_clk,
  input wire logic i_load_drive,
  input wire logic i_measure,
  output logic [15:0] o_on_cycles,
  output logic [15:0] o_edges,
  output logic [15:0] o_min_dwell
);
  logic last_level; // Drive level at the previous edge
  logic [15:0] run_len; // Cycles spent at the present level

  // ==========================================================
  // Previous level, kept even outside a window
  always_ff @(posedge i_sys_clk) begin
    last_level <= i_load_drive;
  end

  // ==========================================================
  // Window counters; a closed window clears the counts and sets the minimum dwell to ffff
  always_ff @(posedge i_sys_clk) begin
    if (!i_measure) begin
      o_on_cycles <= 16'h0000;
      o_edges <= 16'h0000;
      o_min_dwell <= 16'hffff;
      run_len <= 16'h0000;
    end else begin
      o_on_cycles <= o_on_cycles + 16'(i_load_drive);
      if (i_load_drive != last_level) begin
        o_edges <= o_edges + 16'h0001;
        run_len <= 16'h0001;
        // The first edge closes a partial run, so it sets no dwell
        if (o_edges != 16'h0000 && run_len < o_min_dwell) begin
          o_min_dwell <= run_len;
        end
      end else begin
        run_len <= run_len + 16'h0001;
      end
    end
  end
endmodule : switching_load_model
